// ===== common/hba_cap_pkg.sv
// Constants for the upper capability fields of the adapter capability word.
// Assumes byte addressing inside the native register block.
package hba_cap_pkg;

  // Register map
  localparam logic [11:0] CAP_OFFSET = 12'h000;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Field positions inside the capability word
  localparam int SPEED_MSB = 23;
  localparam int SPEED_LSB = 20;
  localparam int RSVD_BIT = 19;
  localparam int NATIVE_BIT = 18;
  localparam int MULT_BIT = 17;
  localparam int FRAME_BIT = 16;
  localparam int PIO_BIT = 15;
  localparam int SLEEP_BIT = 14;
  localparam int UPPER_LSB = 14;
  localparam int UPPER_W = 10;

  // Speed codes, shared with the per-port speed limit field
  typedef enum logic [3:0] {
    SPEED_NONE = 4'h0,
    SPEED_GEN1 = 4'h1,
    SPEED_GEN2 = 4'h2,
    SPEED_GEN3 = 4'h3
  } speed_t;

  // Fixed field values
  localparam logic RSVD_VALUE = 1'h0;
  localparam logic PIO_MULTI_VALUE = 1'h1;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

endpackage

// ===== logic/cap_field_build.sv
// Builds the ten upper capability bits from implementation straps.
// Assumes straps are elaboration constants; no clock needed.
`timescale 1ns/100ps
`default_nettype none
module cap_field_build #(
  parameter logic [3:0] SPEED = 4'h3,
  parameter logic NATIVE_ONLY = 1'h1,
  parameter logic MULTIPLIER = 1'h1,
  parameter logic FRAME_SWITCH = 1'h1,
  parameter logic DEEP_SLEEP = 1'h1
) (
  output logic [9:0] fields
);

  logic [3:0] speedLegal;

  always_comb begin
    // reserved codes fall back to first generation
    if (SPEED >= hba_cap_pkg::SPEED_GEN1 && SPEED <= hba_cap_pkg::SPEED_GEN3) begin
      speedLegal = SPEED;
    end else begin
      speedLegal = hba_cap_pkg::SPEED_GEN1;
    end
  end

  // reserved bit, frame switching needs multiplier, multi block
  assign fields = {speedLegal, hba_cap_pkg::RSVD_VALUE, NATIVE_ONLY, MULTIPLIER,
                   FRAME_SWITCH & MULTIPLIER, hba_cap_pkg::PIO_MULTI_VALUE, DEEP_SLEEP};

endmodule // cap_field_build
`default_nettype wire

// ===== logic/hba_capability_upper_fields.sv
// Read-only upper capability fields (bits 23..14) of the adapter capability word.
// Assumes a simple one-cycle register port; other capability bits read as zero here.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Maximum link speed is four bits: 1, 2, 3 legal; others reserved.
// - Speed code uses the same encoding as each port speed limit field.
// - Bit 19 is reserved and reads zero.
// - Native-only flag is one when no legacy task-file interface exists.
// - Multiplier flag set only when command-based port multipliers are supported.
// - Frame switching flag set only when frame-based switching is supported.
// - Frame switching flag never one unless multiplier flag is one.
// - Multi-block PIO flag tells whether PIO spans several data blocks.
// - Multi-block PIO flag always reads one.
// - Deep sleep flag one means adapter and drive initiated sleep supported.
module hba_capability_upper_fields #(
  parameter logic [3:0] SPEED = 4'h3,
  parameter logic NATIVE_ONLY = 1'h1,
  parameter logic MULTIPLIER = 1'h1,
  parameter logic FRAME_SWITCH = 1'h1,
  parameter logic DEEP_SLEEP = 1'h1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  input wire logic [3:0] portSpeedLimit,
  output logic portSpeedAllowed,
  output logic [3:0] maxLinkSpeed,
  output logic nativeOnlyFlag,
  output logic multiplierSupport,
  output logic frameSwitchingSupport,
  output logic multiBlockPioSupport,
  output logic deepSleepCapable,
  output logic writeIgnored
);

  logic [9:0] fields;
  logic [31:0] capWord;
  logic capHit;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic allowed_q;
  logic ignored_q;
  logic [9:0] flags_q;

  cap_field_build #(
    .SPEED(SPEED),
    .NATIVE_ONLY(NATIVE_ONLY),
    .MULTIPLIER(MULTIPLIER),
    .FRAME_SWITCH(FRAME_SWITCH),
    .DEEP_SLEEP(DEEP_SLEEP)
  ) u_build (
    .fields(fields)
  );

  // Bits outside 23..14 belong to other blocks and read zero here
  assign capWord = {8'h00, fields, 14'h0000};
  assign capHit = (regAddr == hba_cap_pkg::CAP_OFFSET);

  // Read path: one cycle latency, unmapped offsets return zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= hba_cap_pkg::READ_RESET;
      rvalid_q <= 1'h0;
    end else begin
      rvalid_q <= regRead;
      if (regRead && capHit) begin
        rdata_q <= capWord;
      end else if (regRead) begin
        rdata_q <= hba_cap_pkg::READ_RESET;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ignored_q <= 1'h0;
    end else begin
      ignored_q <= regWrite && capHit;
    end
  end

  // Field copies for the link and power logic
  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_q <= 10'h000;
    end else begin
      flags_q <= fields;
    end
  end

  // same code space, so direct compare; zero limit means no restriction
  always_ff @(posedge mclk) begin
    if (srst) begin
      allowed_q <= 1'h0;
    end else begin
      allowed_q <= (portSpeedLimit == hba_cap_pkg::SPEED_NONE) ||
                   (portSpeedLimit <= fields[9:6]);
    end
  end

  assign regRdata = rdata_q;
  assign regRvalid = rvalid_q;
  assign writeIgnored = ignored_q;
  assign portSpeedAllowed = allowed_q;
  assign maxLinkSpeed = flags_q[9:6];
  assign nativeOnlyFlag = flags_q[4];
  assign multiplierSupport = flags_q[3];
  assign frameSwitchingSupport = flags_q[2];
  assign multiBlockPioSupport = flags_q[1];
  // Link power logic honours both initiators when set
  assign deepSleepCapable = flags_q[0];

  // Assertion helpers: write data is never stored, so it is unused by design
  logic wdataSeen;
  assign wdataSeen = |regWdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence capRead;
    regRead && capHit;
  endsequence

  sequence otherRead;
    regRead && !capHit;
  endsequence

  sequence capWriteThenRead;
    (regWrite && capHit && wdataSeen) ##1 capRead;
  endsequence

  sequence otherWrite;
    regWrite && !capHit;
  endsequence

  a_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered next cycle");

  a_no_spurious_answer: assert property (!regRead |=> !regRvalid)
    else $error("answer without read");

  a_speed_legal: assert property (capRead |=> regRdata[23:20] >= 4'h1 &&
                                  regRdata[23:20] <= 4'h3)
    else $error("speed code reserved");

  a_reserved_zero: assert property (capRead |=> regRdata[19] == 1'h0)
    else $error("reserved bit 19 set");

  a_native_flag: assert property (capRead |=> regRdata[18] == NATIVE_ONLY)
    else $error("native only flag wrong");

  a_mult_flag: assert property (capRead |=> regRdata[17] == MULTIPLIER)
    else $error("multiplier flag wrong");

  a_frame_flag: assert property (capRead |=> regRdata[16] ==
                                 (FRAME_SWITCH & MULTIPLIER))
    else $error("frame switching flag wrong");

  a_frame_needs_mult: assert property (regRvalid && regRdata[16] |-> regRdata[17])
    else $error("frame switching without multiplier");

  a_pio_multi: assert property (capRead |=> regRdata[15] && multiBlockPioSupport)
    else $error("multi block PIO flag clear");

  a_pio_matches: assert property (capRead |=> regRdata[15] == multiBlockPioSupport)
    else $error("PIO flag and output disagree");

  a_sleep_flag: assert property (capRead |=> regRdata[14] == deepSleepCapable &&
                                 regRdata[14] == DEEP_SLEEP)
    else $error("deep sleep flag wrong");

  a_write_ignored: assert property (capWriteThenRead |=> regRdata == capWord)
    else $error("write changed capability word");

  a_write_flagged: assert property (regWrite && capHit |=> writeIgnored ##1
                                    (writeIgnored == $past(regWrite && capHit)))
    else $error("ignored write not flagged");

  a_other_zero: assert property (otherRead |=> regRdata == 32'h0000_0000)
    else $error("unmapped offset returned data");

  a_speed_compare: assert property (portSpeedLimit > maxLinkSpeed &&
                                    $stable(portSpeedLimit) && $stable(maxLinkSpeed)
                                    |=> !portSpeedAllowed)
    else $error("port limit above maximum allowed");

  a_speed_hold: assert property (capRead ##1 capRead |=> $stable(regRdata[23:20]))
    else $error("speed field changed between reads");

  a_outside_zero: assert property (regRvalid |->
                                   {regRdata[31:24], regRdata[13:0]} == 22'h000000)
    else $error("bits outside the field range set");

  a_speed_copy: assert property (capRead |=> regRdata[23:20] == maxLinkSpeed)
    else $error("speed output and read word disagree");

  a_flags_copy: assert property (capRead |=>
                                 regRdata[18:14] == {nativeOnlyFlag, multiplierSupport,
                                 frameSwitchingSupport, multiBlockPioSupport, deepSleepCapable})
    else $error("flag outputs and read word disagree");

  a_zero_limit: assert property (portSpeedLimit == 4'h0 |=> portSpeedAllowed)
    else $error("zero port limit refused");

  a_limit_within: assert property (portSpeedLimit != 4'h0 &&
                                   portSpeedLimit <= maxLinkSpeed && $stable(maxLinkSpeed)
                                   |=> portSpeedAllowed)
    else $error("port limit within maximum refused");

  a_unmapped_write: assert property (otherWrite |=> !writeIgnored)
    else $error("write to other offset flagged");

endmodule // hba_capability_upper_fields
`default_nettype wire

// ===== tb/hba_capability_upper_fields_bench.sv
// Self-checking bench for the upper capability fields block.
// Assumes default straps; the bench drives the register port itself.
`timescale 1ns/100ps
`default_nettype none
module hba_capability_upper_fields_bench;
  localparam logic [31:0] CAP_WORD = (32'h3 << hba_cap_pkg::SPEED_LSB)
    | (32'h1 << hba_cap_pkg::NATIVE_BIT) | (32'h1 << hba_cap_pkg::MULT_BIT)
    | (32'h1 << hba_cap_pkg::FRAME_BIT) | (32'h1 << hba_cap_pkg::PIO_BIT)
    | (32'h1 << hba_cap_pkg::SLEEP_BIT);
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic [11:0] regAddr = 12'h000;
  logic regRead = 1'h0;
  logic regWrite = 1'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [3:0] portSpeedLimit = 4'h0;
  logic [31:0] regRdata;
  logic [3:0] maxLinkSpeed;
  logic regRvalid, portSpeedAllowed, nativeOnlyFlag, multiplierSupport;
  logic frameSwitchingSupport, multiBlockPioSupport, deepSleepCapable, writeIgnored;
  logic [15:0] lfsr = 16'h0039;
  logic [31:0] rq[$];
  bit wq[$];
  int mismatches = 0;
  int numChecks = 0;

  hba_capability_upper_fields u_dut (.mclk(mclk), .srst(srst), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .portSpeedLimit(portSpeedLimit),
    .portSpeedAllowed(portSpeedAllowed), .maxLinkSpeed(maxLinkSpeed),
    .nativeOnlyFlag(nativeOnlyFlag), .multiplierSupport(multiplierSupport),
    .frameSwitchingSupport(frameSwitchingSupport),
    .multiBlockPioSupport(multiBlockPioSupport), .deepSleepCapable(deepSleepCapable),
    .writeIgnored(writeIgnored));

  initial begin
    forever #50 mclk = ~mclk;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic fail(input string msg);
    mismatches++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp);
    numChecks++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One request per cycle; strobes stay up between back-to-back requests
  task automatic drive(input logic rd, input logic wr, input logic [11:0] a);
    @(posedge mclk);
    #1;
    lfsr = next_rand(lfsr);
    regRead = rd;
    regWrite = wr;
    regAddr = a;
    regWdata = {lfsr, ~lfsr};
    if (rd) rq.push_back((a == hba_cap_pkg::CAP_OFFSET) ? CAP_WORD : 32'h0000_0000);
    if (wr && a == hba_cap_pkg::CAP_OFFSET) wq.push_back(1'h1);
  endtask

  task automatic drain();
    int n;
    drive(1'h0, 1'h0, 12'h000);
    for (n = 0; n < 20 && (rq.size() > 0 || wq.size() > 0); n++) @(posedge mclk);
    if (rq.size() > 0 || wq.size() > 0) begin
      fail("answers missing");
      tally_and_finish();
    end
  endtask

  task automatic check_fields();
    check_word({28'h0, maxLinkSpeed}, {28'h0, hba_cap_pkg::SPEED_GEN3});
    check_bit(nativeOnlyFlag, 1'h1);
    check_bit(multiplierSupport, 1'h1);
    check_bit(frameSwitchingSupport, 1'h1);
    check_bit(multiBlockPioSupport, 1'h1);
    // flag set, so deep sleep may be requested
    check_bit(deepSleepCapable, 1'h1);
  endtask

  always @(negedge mclk) begin
    if (regRvalid === 1'h1) begin
      if (rq.size() == 0) fail("read answer without request");
      else check_word(regRdata, rq.pop_front());
    end
    if (writeIgnored === 1'h1) begin
      if (wq.size() == 0) fail("write notice without write");
      else check_bit(writeIgnored, wq.pop_front());
    end
  end

  // Watchdog kept well inside the run budget
  initial begin
    #2_000_000;
    fail("run timed out");
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge mclk);
    #1 srst = 1'h0;
    repeat (2) @(posedge mclk);
    #1 check_fields();
    $display("test fields done");
    // Reads in pairs, so the held-speed check sees back-to-back hits
    for (int i = 0; i < 8; i++) drive(1'h1, 1'h0, i[1] ? (lfsr[11:0] | 12'h004) : 12'h000);
    drain();
    $display("test back-to-back reads done");
    // Last write hits the word right before a read of it
    for (int i = 0; i < 4; i++) drive(1'h0, 1'h1, i[0] ? 12'h000 : 12'h004);
    drive(1'h1, 1'h0, 12'h000);
    drain();
    check_fields();
    $display("test writes done");
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      #1 portSpeedLimit = i[3:0];
      repeat (2) @(posedge mclk);
      #1 check_bit(portSpeedAllowed, i <= 3);
    end
    $display("test speed compare done");
    @(posedge mclk);
    #1 srst = 1'h1;
    repeat (2) @(posedge mclk);
    #1 check_word({28'h0, maxLinkSpeed}, 32'h0);
    check_bit(portSpeedAllowed, 1'h0);
    srst = 1'h0;
    drive(1'h1, 1'h0, 12'h000);
    drain();
    check_fields();
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule // hba_capability_upper_fields_bench
`default_nettype wire
